// file: rtl/adc_status_flags.sv
`timescale 1ns/1ps
// Status flags, serial read path and shared data-out pin
module adc_status_flags
   import adc_status_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire logic              sclk_i,
   input  wire logic              cs_n_i,
   input  wire logic              din_i,
   output logic                   dout_o,
   output logic                   dout_oe_o,
   input  wire logic              result_wr_i,
   input  wire logic [DATA_W-1:0] result_i,
   input  wire logic              over_range_i,
   input  wire logic              under_range_i,
   input  wire logic [CHAN_W-1:0] result_chan_i,
   input  wire logic              cal_mode_i,
   input  wire logic              cal_done_i,
   input  wire logic              append_status_i,
   input  wire logic              crc_wr_fail_i,
   input  wire logic              reg_check_en_i,
   input  wire logic              reg_mismatch_i,
   output logic [STAT_W-1:0]      status_o
);

   link_evt_if evt ();

   logic [DATA_W-1:0] data_w;      // Stored result from the capture block
   logic              range_err_w; // Range error flag
   logic [CHAN_W-1:0] chan_w;      // Channel tag
   logic [STAT_W-1:0] status_w;    // Assembled status word

   // Link state
   link_state_type    state_r;
   link_state_type    state_nxt;
   logic [CMD_W-1:0]  cmd_r;       // Command byte being shifted in
   logic [CMD_W-1:0]  cmd_nxt;
   logic [CMD_W-1:0]  cmd_w;       // Command byte including current bit
   logic [5:0]        cnt_r;       // Bits done in the current phase
   logic [5:0]        cnt_nxt;
   logic [5:0]        len_r;       // Bits in the current read
   logic [5:0]        len_nxt;
   logic [SH_W-1:0]   sh_r;        // Read shift register, MSB first
   logic [SH_W-1:0]   sh_nxt;
   logic              data_rd_r;   // Current read targets the data register
   logic              data_rd_nxt;
   logic              stat_clr;    // Pulse: status word handed to host
   logic              data_done;   // Pulse: data register read finished

   // Flags and outputs
   logic              rdy_r;
   logic              rdy_nxt;
   logic              crc_r;
   logic              crc_nxt;
   logic              reg_r;
   logic              reg_nxt;
   logic              dout_r;
   logic              dout_nxt;
   logic              oe_r;
   logic              oe_nxt;
   logic [STAT_W-1:0] stat_r;
   logic [STAT_W-1:0] stat_nxt;

   link_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .sclk_i    (sclk_i),
      .cs_n_i    (cs_n_i),
      .din_i     (din_i),
      .evt       (evt)
   );

   // Calibration results do not land in the data register
   result_capture u_capture (
      .clk_sys_i     (clk_sys_i),
      .rst_i         (rst_i),
      .result_wr_i   (result_wr_i & ~cal_mode_i),
      .result_i      (result_i),
      .over_range_i  (over_range_i),
      .under_range_i (under_range_i),
      .result_chan_i (result_chan_i),
      .data_o        (data_w),
      .range_err_o   (range_err_w),
      .chan_o        (chan_w)
   );

   // Status word; reserved bits tied to zero
   always_comb begin
      status_w                           = '0;
      status_w[BIT_RDY]                  = rdy_r;
      status_w[BIT_RANGE]                = range_err_w;
      status_w[BIT_CRC]                  = crc_r;
      status_w[BIT_REGCHK]               = reg_r;
      status_w[3:2]                      = RSV_VALUE;
      status_w[CHAN_LSB +: CHAN_W]       = chan_w;
   end

   assign cmd_w = {cmd_r[CMD_W-2:0], evt.din};

   // Serial link sequencer: command byte in, register read out
   always_comb begin
      state_nxt   = state_r;
      cmd_nxt     = cmd_r;
      cnt_nxt     = cnt_r;
      len_nxt     = len_r;
      sh_nxt      = sh_r;
      data_rd_nxt = data_rd_r;
      stat_clr    = 1'b0;
      data_done   = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (evt.cs_low) begin
               state_nxt = ST_CMD;
               cnt_nxt   = 6'h00;
            end
         end
         ST_CMD: begin
            if (!evt.cs_low) begin
               state_nxt = ST_IDLE;
            end else if (evt.sclk_rise) begin
               cmd_nxt = cmd_w;
               if (cnt_r == LEN_CMD - 6'h01) begin
                  cnt_nxt = 6'h00;
                  if (cmd_w[CMD_WEN_BIT]) begin
                     // Enable bit high: not a command, wait for another
                     state_nxt = ST_CMD;
                  end else if (!cmd_w[CMD_RW_BIT]) begin
                     // Writes belong to other registers; sit out the frame
                     state_nxt = ST_SKIP;
                  end else begin
                     state_nxt = ST_READ;
                     if (cmd_w[5:0] == ADDR_STATUS) begin
                        sh_nxt      = {status_w, {DATA_W{1'b0}}};
                        len_nxt     = LEN_STATUS;
                        stat_clr    = 1'b1;
                        data_rd_nxt = 1'b0;
                     end else if (cmd_w[5:0] == ADDR_DATA) begin
                        sh_nxt      = {data_w, status_w};
                        data_rd_nxt = 1'b1;
                        if (append_status_i) begin
                           len_nxt  = LEN_DATA_STAT;
                           stat_clr = 1'b1;
                        end else begin
                           len_nxt  = LEN_DATA;
                        end
                     end else begin
                        // Other registers live elsewhere; read as zero
                        sh_nxt      = '0;
                        len_nxt     = LEN_OTHER;
                        data_rd_nxt = 1'b0;
                     end
                  end
               end else begin
                  cnt_nxt = cnt_r + 6'h01;
               end
            end
         end
         ST_READ: begin
            if (!evt.cs_low) begin
               // Aborted read: data register not counted as read
               state_nxt   = ST_IDLE;
               data_rd_nxt = 1'b0;
            end else begin
               if (evt.sclk_fall) begin
                  sh_nxt = {sh_r[SH_W-2:0], 1'b0};
               end
               if (evt.sclk_rise) begin
                  if (cnt_r == len_r - 6'h01) begin
                     state_nxt   = ST_CMD;
                     cnt_nxt     = 6'h00;
                     data_done   = data_rd_r;
                     data_rd_nxt = 1'b0;
                  end else begin
                     cnt_nxt = cnt_r + 6'h01;
                  end
               end
            end
         end
         ST_SKIP: begin
            if (!evt.cs_low) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         state_r   <= ST_IDLE;
         cmd_r     <= '0;
         cnt_r     <= 6'h00;
         len_r     <= LEN_STATUS;
         sh_r      <= '0;
         data_rd_r <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cmd_r     <= cmd_nxt;
         cnt_r     <= cnt_nxt;
         len_r     <= len_nxt;
         sh_r      <= sh_nxt;
         data_rd_r <= data_rd_nxt;
      end
   end

   // Flags; a hardware event in the same cycle as a clear wins, except that disabling the check beats a mismatch
   always_comb begin
      rdy_nxt = rdy_r;
      if (cal_mode_i ? cal_done_i : result_wr_i) begin
         rdy_nxt = 1'b0;
      end else if (data_done) begin
         rdy_nxt = 1'b1;
      end
      // Sticky through later good writes until a status read
      crc_nxt = crc_wr_fail_i | (crc_r & ~stat_clr);
      // Only dropping the check enable clears it
      reg_nxt = reg_check_en_i & (reg_r | reg_mismatch_i);
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdy_r <= STATUS_RST[BIT_RDY];
         crc_r <= STATUS_RST[BIT_CRC];
         reg_r <= STATUS_RST[BIT_REGCHK];
      end else begin
         rdy_r <= rdy_nxt;
         crc_r <= crc_nxt;
         reg_r <= reg_nxt;
      end
   end

   // Pin and status outputs, all registered
   always_comb begin
      oe_nxt   = evt.cs_low;
      stat_nxt = status_w;
      if (state_nxt == ST_READ) begin
         dout_nxt = sh_nxt[SH_W-1];
      end else begin
         dout_nxt = rdy_nxt;
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         dout_r <= STATUS_RST[BIT_RDY];
         oe_r   <= 1'b0;
         stat_r <= STATUS_RST;
      end else begin
         dout_r <= dout_nxt;
         oe_r   <= oe_nxt;
         stat_r <= stat_nxt;
      end
   end

   assign dout_o    = dout_r;
   assign dout_oe_o = oe_r;
   assign status_o  = stat_r;

endmodule

// file: rtl/adc_status_pkg.sv
// Summary of operation
// - Eight-bit status word resets to 0x80
// - Append status byte after result when enabled
// - Data-out shows ready bit outside register reads
// - Ready bit cleared when new result written
// - Calibration mode: cleared on calibration result instead
// - Ready bit set after data register read
// - Range error sets flag, saturates stored result
// - Range flag updates only on result writes
// - Failed write checksum sets serial error flag
// - Status read clears serial error flag
// - Register check mismatch sets integrity flag
// - Integrity flag cleared by disabling check
// - Channel tag gives result's channel index
// - Reserved status bits read as zero
package adc_status_pkg;

   // Widths of the words on the serial link
   localparam int STAT_W = 8;
   localparam int DATA_W = 24;
   localparam int CMD_W  = 8;
   localparam int SH_W   = 32;
   localparam int CHAN_W = 2;

   // Status word layout
   localparam int BIT_RDY    = 7;
   localparam int BIT_RANGE  = 6;
   localparam int BIT_CRC    = 5;
   localparam int BIT_REGCHK = 4;
   localparam int CHAN_LSB   = 0;

   // Values after reset
   localparam logic [STAT_W-1:0] STATUS_RST = 8'h80;
   localparam logic [DATA_W-1:0] DATA_RST   = 24'h000000;
   localparam logic [CHAN_W-1:0] CHAN_RST   = 2'h0;
   localparam logic [1:0]        RSV_VALUE  = 2'h0;

   // Saturation values for out-of-range results
   localparam logic [DATA_W-1:0] SAT_HIGH = 24'hFFFFFF;
   localparam logic [DATA_W-1:0] SAT_LOW  = 24'h000000;

   // Command byte layout and register addresses
   localparam int CMD_WEN_BIT = 7;
   localparam int CMD_RW_BIT  = 6;
   localparam logic [5:0] ADDR_STATUS = 6'h00;
   localparam logic [5:0] ADDR_DATA   = 6'h04;

   // Bit counts of each transfer
   localparam logic [5:0] LEN_CMD       = 6'h08;
   localparam logic [5:0] LEN_STATUS    = 6'h08;
   localparam logic [5:0] LEN_DATA      = 6'h18;
   localparam logic [5:0] LEN_DATA_STAT = 6'h20;
   localparam logic [5:0] LEN_OTHER     = 6'h08;

   // Number of synchronised pin inputs
   localparam int SYNC_PINS = 3;

   // Serial link states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CMD  = 4'h2,
      ST_READ = 4'h4,
      ST_SKIP = 4'h8
   } link_state_type;

endpackage

// file: rtl/link_evt_if.sv
`timescale 1ns/1ps
// Synchronised serial pin levels and clock edge events
interface link_evt_if;
   logic cs_low;    // Chip select asserted
   logic sclk_rise; // One-cycle pulse on serial clock rising edge
   logic sclk_fall; // One-cycle pulse on serial clock falling edge
   logic din;       // Synchronised serial input level

   modport src (output cs_low, output sclk_rise, output sclk_fall, output din);
   modport dst (input cs_low, input sclk_rise, input sclk_fall, input din);
endinterface

// file: rtl/link_sync.sv
`timescale 1ns/1ps
// Brings the serial pins into the system clock and finds clock edges
module link_sync
   import adc_status_pkg::*;
(
   input  wire logic   clk_sys_i,
   input  wire logic   rst_i,
   input  wire logic   sclk_i,
   input  wire logic   cs_n_i,
   input  wire logic   din_i,
   link_evt_if.src     evt
);

   logic [SYNC_PINS-1:0] pins;     // Raw pins, 0 clock, 1 select, 2 data
   logic [SYNC_PINS-1:0] meta_r;   // First stage, read only by stage two
   logic [SYNC_PINS-1:0] meta_nxt;
   logic [SYNC_PINS-1:0] stab_r;   // Second stage, safe to use
   logic [SYNC_PINS-1:0] stab_nxt;
   logic                 sclk_d_r; // Previous stable clock level
   logic                 sclk_d_nxt;

   assign pins = {din_i, cs_n_i, sclk_i};

   // Two flops per pin; select resets high so the link starts idle
   genvar g;
   generate
      for (g = 0; g < SYNC_PINS; g++) begin : g_sync
         always_comb begin
            meta_nxt[g] = pins[g];
            stab_nxt[g] = meta_r[g];
         end
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               meta_r[g] <= 1'b1;
               stab_r[g] <= 1'b1;
            end else begin
               meta_r[g] <= meta_nxt[g];
               stab_r[g] <= stab_nxt[g];
            end
         end
      end
   endgenerate

   // Delayed clock level for edge finding
   always_comb begin
      sclk_d_nxt = stab_r[0];
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_d_nxt;
      end
   end

   assign evt.sclk_rise = stab_r[0] & ~sclk_d_r;
   assign evt.sclk_fall = ~stab_r[0] & sclk_d_r;
   assign evt.cs_low    = ~stab_r[1];
   assign evt.din       = stab_r[2];

endmodule

// file: rtl/result_capture.sv
`timescale 1ns/1ps
// Data register with saturation, range flag and channel tag
module result_capture
   import adc_status_pkg::*;
(
   input  wire logic              clk_sys_i,
   input  wire logic              rst_i,
   input  wire logic              result_wr_i,
   input  wire logic [DATA_W-1:0] result_i,
   input  wire logic              over_range_i,
   input  wire logic              under_range_i,
   input  wire logic [CHAN_W-1:0] result_chan_i,
   output logic      [DATA_W-1:0] data_o,
   output logic                   range_err_o,
   output logic      [CHAN_W-1:0] chan_o
);

   logic [DATA_W-1:0] data_r;      // Stored result
   logic [DATA_W-1:0] data_nxt;
   logic              range_r;     // Range error flag
   logic              range_nxt;
   logic [CHAN_W-1:0] chan_r;      // Channel of stored result
   logic [CHAN_W-1:0] chan_nxt;

   // Everything changes only on a result write, so the flag follows
   // the range condition of the latest result
   always_comb begin
      data_nxt  = data_r;
      range_nxt = range_r;
      chan_nxt  = chan_r;
      if (result_wr_i) begin
         range_nxt = over_range_i | under_range_i;
         chan_nxt  = result_chan_i;
         if (over_range_i) begin
            data_nxt = SAT_HIGH;
         end else if (under_range_i) begin
            data_nxt = SAT_LOW;
         end else begin
            data_nxt = result_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         data_r  <= DATA_RST;
         range_r <= 1'b0;
         chan_r  <= CHAN_RST;
      end else begin
         data_r  <= data_nxt;
         range_r <= range_nxt;
         chan_r  <= chan_nxt;
      end
   end

   assign data_o      = data_r;
   assign range_err_o = range_r;
   assign chan_o      = chan_r;

endmodule

// file: tb/adc_status_flags_props.sv
`timescale 1ns/1ps
// Checker on the ports of the status flag block
module adc_status_flags_props
   import adc_status_pkg::*;
(
   input wire logic              clk_sys_i,
   input wire logic              rst_i,
   input wire logic              cs_n_i,
   input wire logic              dout_o,
   input wire logic              dout_oe_o,
   input wire logic              result_wr_i,
   input wire logic [CHAN_W-1:0] result_chan_i,
   input wire logic              over_range_i,
   input wire logic              under_range_i,
   input wire logic              cal_mode_i,
   input wire logic              cal_done_i,
   input wire logic              crc_wr_fail_i,
   input wire logic              reg_check_en_i,
   input wire logic              reg_mismatch_i,
   input wire logic [STAT_W-1:0] status_o
);
   // One clock domain, so one default clock and reset
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_reset_word: assert property ($past(rst_i) |-> status_o == STATUS_RST)
      else $error("status word not at reset value");
   a_rsv_zero: assert property (status_o[3:2] == RSV_VALUE)
      else $error("reserved status bits not zero");
   // Status word lags the event by two edges
   a_ready_clear: assert property (result_wr_i && !cal_mode_i |-> ##2 !status_o[7])
      else $error("ready bit not cleared by result");
   a_cal_clear: assert property (cal_mode_i && cal_done_i |-> ##2 !status_o[7])
      else $error("ready bit not cleared by calibration");
   a_range_flag: assert property (result_wr_i && !cal_mode_i
      |-> ##2 status_o[6] == $past(over_range_i | under_range_i, 2))
      else $error("range flag wrong after result");
   a_range_hold: assert property ($changed(status_o[6]) |-> $past(result_wr_i, 2))
      else $error("range flag moved without result");
   a_chan_tag: assert property (result_wr_i && !cal_mode_i
      |-> ##2 status_o[1:0] == $past(result_chan_i, 2))
      else $error("channel tag wrong");
   a_crc_set: assert property (crc_wr_fail_i |-> ##2 status_o[5])
      else $error("serial error flag not set");
   // The flag may only drop inside a frame, where a status read happens
   a_crc_sticky: assert property ($fell(status_o[5]) |-> dout_oe_o)
      else $error("serial error flag dropped outside a read");
   a_reg_set: assert property (reg_check_en_i && reg_mismatch_i |-> ##2 status_o[4])
      else $error("integrity flag not set");
   a_reg_clear: assert property (!reg_check_en_i |-> ##2 !status_o[4])
      else $error("integrity flag not cleared");
   a_ready_pin: assert property ($fell(cs_n_i)
      |-> ##[2:5] (dout_oe_o && dout_o == status_o[7]))
      else $error("pin does not show ready bit");
   a_pin_off: assert property ($rose(cs_n_i) |-> ##[2:5] !dout_oe_o)
      else $error("pin still driven after deselect");
endmodule

bind adc_status_flags adc_status_flags_props adc_status_flags_props_i (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .dout_o(dout_o),
   .dout_oe_o(dout_oe_o), .result_wr_i(result_wr_i), .result_chan_i(result_chan_i),
   .over_range_i(over_range_i), .under_range_i(under_range_i),
   .cal_mode_i(cal_mode_i), .cal_done_i(cal_done_i), .crc_wr_fail_i(crc_wr_fail_i),
   .reg_check_en_i(reg_check_en_i), .reg_mismatch_i(reg_mismatch_i),
   .status_o(status_o));

// file: tb/link_host.sv
`timescale 1ns/1ps
// Host side of the serial link, clock idles high
module link_host (
   input  wire logic clk_sys_i,
   input  wire logic dout_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o
);
   // Link idle: deselected, clock high
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b1;
   end

   // One frame: command byte then n read bits, 400 ns link period
   task automatic xfer(input logic [7:0] cmd, input int n,
                       output logic [31:0] rd, output logic rdy);
      rd = 32'h0;
      @(posedge clk_sys_i);
      cs_n_o <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      rdy = dout_i;
      for (int i = 0; i < 8 + n; i++) begin
         @(posedge clk_sys_i);
         sclk_o <= 1'b0;
         din_o  <= (i < 8) ? cmd[7-i] : 1'b0;
         repeat (2) @(posedge clk_sys_i);
         #1;
         // Sample two clocks after the fall, well inside the bit
         // Read bits carry no integrity flag; judging them is ours
         if (i >= 8) begin
            rd = {rd[30:0], dout_i};
         end
         repeat (2) @(posedge clk_sys_i);
         sclk_o <= 1'b1;
         repeat (3) @(posedge clk_sys_i);
      end
      @(posedge clk_sys_i);
      cs_n_o <= 1'b1;
      // Released data line must not keep its last level
      din_o  <= ~din_o;
      repeat (8) @(posedge clk_sys_i);
   endtask
endmodule

// file: tb/test_adc_status_flags.sv
`timescale 1ns/1ps
// Self-checking bench for the status flag block
module test_adc_status_flags
   import adc_status_pkg::*;
();
   logic              clk_sys_i       = 1'b0;
   logic              rst_i           = 1'b1;
   logic              sclk_w;         // Link clock from host
   logic              cs_n_w;         // Chip select from host
   logic              din_w;          // Command bits from host
   logic              dout_o;
   logic              dout_oe_o;
   logic              dout_w;         // Level seen by host
   logic              result_wr_i     = 1'b0;
   logic [DATA_W-1:0] result_i        = 24'h000000;
   logic              over_range_i    = 1'b0;
   logic              under_range_i   = 1'b0;
   logic [CHAN_W-1:0] result_chan_i   = 2'h0;
   logic              cal_mode_i      = 1'b0;
   logic              cal_done_i      = 1'b0;
   logic              append_status_i = 1'b0;
   logic              crc_wr_fail_i   = 1'b0;
   logic              reg_check_en_i  = 1'b0;
   logic              reg_mismatch_i  = 1'b0;
   logic [STAT_W-1:0] status_o;
   int                errors          = 0;
   int                check_count     = 0;
   logic [DATA_W-1:0] vals [4] = '{24'h123456, 24'h654321, 24'h0F0F0F, 24'hABCDEF};

   // 20 MHz system clock
   always #25 clk_sys_i = ~clk_sys_i;

   // Undriven pin shows a wrong level so stale reads are caught
   assign dout_w = dout_oe_o ? dout_o : !dout_o;

   adc_status_flags adc_status_flags_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w),
      .din_i(din_w), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
      .result_wr_i(result_wr_i), .result_i(result_i), .over_range_i(over_range_i),
      .under_range_i(under_range_i), .result_chan_i(result_chan_i),
      .cal_mode_i(cal_mode_i), .cal_done_i(cal_done_i),
      .append_status_i(append_status_i), .crc_wr_fail_i(crc_wr_fail_i),
      .reg_check_en_i(reg_check_en_i), .reg_mismatch_i(reg_mismatch_i),
      .status_o(status_o));

   link_host link_host_i (
      .clk_sys_i(clk_sys_i), .dout_i(dout_w), .sclk_o(sclk_w), .cs_n_o(cs_n_w),
      .din_o(din_w));

   // Status word compare, after the edge's updates land
   task automatic chk_stat(input logic [STAT_W-1:0] exp);
      #1;
      check_count++;
      if (status_o !== exp) begin
         errors++;
         $display("[ERR] %0t status %h expected %h", $time, status_o, exp);
      end
   endtask

   // Serial read compare
   task automatic chk_link(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t link read %h expected %h", $time, got, exp);
      end
   endtask

   // Frame with read data and the ready level seen before the command
   task automatic rd(input logic [7:0] cmd, input int n, input logic [31:0] exp,
                     input logic rdy);
      logic [31:0] got;
      logic        r;
      link_host_i.xfer(cmd, n, got, r);
      chk_link(got, exp);
      chk_link({31'h0, r}, {31'h0, rdy});
   endtask

   // One conversion result pulse
   task automatic conv(input logic [1:0] ch, input logic [23:0] v, input logic ov,
                       input logic un);
      @(posedge clk_sys_i);
      result_wr_i   <= 1'b1;
      result_i      <= v;
      result_chan_i <= ch;
      over_range_i  <= ov;
      under_range_i <= un;
      @(posedge clk_sys_i);
      result_wr_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
   endtask

   task automatic print_verdict;
      $display("Errors %0d, checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      logic [7:0]  st;
      logic [23:0] d;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      chk_stat(8'h80);
      rd(8'h40, 8, 32'h80, 1'b1);
      // Each channel, with over, under and back in range
      for (int c = 0; c < 4; c++) begin
         d  = (c == 1) ? SAT_HIGH : (c == 2) ? SAT_LOW : vals[c];
         st = {1'b0, c == 1 || c == 2, 4'h0, 2'(c)};
         conv(2'(c), vals[c], c == 1, c == 2);
         chk_stat(st);
         @(posedge clk_sys_i);
         append_status_i <= c[0];
         rd(8'h44, c[0] ? 32 : 24, c[0] ? {d, st} : {8'h00, d}, 1'b0);
         chk_stat({1'b1, st[6:0]});
      end
      // Serial write error stays through a write frame
      @(posedge clk_sys_i);
      crc_wr_fail_i <= 1'b1;
      @(posedge clk_sys_i);
      crc_wr_fail_i <= 1'b0;
      // Status word lags the flag by one edge
      @(posedge clk_sys_i);
      chk_stat(8'hA3);
      // Skipped write frame: pin keeps mirroring the ready bit
      rd(8'h01, 16, 32'h0000FFFF, 1'b1);
      chk_stat(8'hA3);
      rd(8'h40, 8, 32'hA3, 1'b1);
      chk_stat(8'h83);
      // Integrity flag holds until the check is disabled
      @(posedge clk_sys_i);
      reg_check_en_i <= 1'b1;
      reg_mismatch_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_mismatch_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      chk_stat(8'h93);
      @(posedge clk_sys_i);
      reg_check_en_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      chk_stat(8'h83);
      // Calibration: only the calibration result clears ready
      @(posedge clk_sys_i);
      cal_mode_i <= 1'b1;
      conv(2'h1, 24'h111111, 1'b1, 1'b0);
      chk_stat(8'h83);
      @(posedge clk_sys_i);
      cal_done_i <= 1'b1;
      @(posedge clk_sys_i);
      cal_done_i <= 1'b0;
      cal_mode_i <= 1'b0;
      @(posedge clk_sys_i);
      chk_stat(8'h03);
      // Unmapped address reads zeros
      rd(8'h47, 8, 32'h0, 1'b0);
      // Second reset mid-run
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      chk_stat(8'h80);
      print_verdict();
   end

   // Whole run needs well under 1 ms
   initial begin
      #2000000;
      errors++;
      print_verdict();
   end
endmodule
